// *** dmct_pkg.sv ***
// Constants and carrier types for the dual mode compare timer.
// Assumes one core clock and a synchronous active-high reset.
package dmct_pkg;

  // ----------------------------------------------------------------
  // Register selects on the 8-bit peripheral port
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_STATUS = 3'h0;
  localparam logic [2:0] REG_CLKCTL = 3'h1;
  localparam logic [2:0] REG_CNT_HI = 3'h2;
  localparam logic [2:0] REG_CNT_LO = 3'h3;
  localparam logic [2:0] REG_CMP_HI = 3'h4;
  localparam logic [2:0] REG_CMP_LO = 3'h5;
  localparam logic [2:0] REG_MSTOP  = 3'h6;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int HI_OVF_POS   = 7;
  localparam int HI_MATCH_POS = 6;
  localparam int HI_OVIE_POS  = 5;
  localparam int HI_CCLR_POS  = 4;
  localparam int LO_OVF_POS   = 3;
  localparam int LO_MATCH_POS = 2;
  localparam int LO_OVIE_POS  = 1;
  localparam int LO_CCLR_POS  = 0;
  localparam int SPLIT_POS    = 6;
  localparam int MSTOP_POS    = 2;

  // ----------------------------------------------------------------
  // Reset values and fixed read values
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] CLKCTL_RST = 8'h00;
  localparam logic [7:0] CNT_RST    = 8'h00;
  localparam logic [7:0] CMP_RST    = 8'hFF;
  localparam logic [7:0] MSTOP_RST  = 8'hFF;
  localparam logic [7:0] BYTE_MAX   = 8'hFF;
  localparam logic [7:0] RD_IDLE    = 8'hFF;

  // ----------------------------------------------------------------
  // Clock selects and prescaler tick masks
  // ----------------------------------------------------------------
  localparam logic [2:0] CKS_DIV32 = 3'h4;
  localparam logic [2:0] CKS_DIV16 = 3'h5;
  localparam logic [2:0] CKS_DIV4  = 3'h6;
  localparam logic [2:0] CKS_SUB4  = 3'h7;
  localparam int         PRE_W     = 7;
  localparam logic [6:0] PRE_RST   = 7'h00;
  localparam logic [6:0] MASK_DIV4 = 7'h03;
  localparam logic [6:0] MASK_D16  = 7'h0F;
  localparam logic [6:0] MASK_D32  = 7'h1F;
  localparam logic [6:0] MASK_SUB  = 7'h7F;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } dmct_req_t;

  typedef struct packed {
    logic div4;
    logic div16;
    logic div32;
    logic sub4;
  } dmct_tick_t;

endpackage

// *** dmct_flag.sv ***
// One hardware-set status flag, cleared by writing 0 after reading it as 1.
// Assumes rd and clr come from the core clock domain.
`timescale 1ns/1ns
module dmct_flag (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic set,
  input  wire logic rd,
  input  wire logic clr,
  output logic      flag_q
);
  logic armed_q;
  logic do_clr;
  logic flag_d;
  logic armed_d;

  // Clear only after the 1 has been seen; a 1 written is no clear
  assign do_clr  = clr & armed_q;             // see RULE_25
  // Set wins over a clear in the same cycle and disarms the read
  assign flag_d  = set | (flag_q & ~do_clr);
  assign armed_d = flag_d & ~do_clr & ~set & (armed_q | (rd & flag_q));

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      flag_q  <= 1'b0;
      armed_q <= 1'b0;
    end
    else
    begin
      flag_q  <= flag_d;
      armed_q <= armed_d;
    end
  end
endmodule

// *** dmct_prescaler.sv ***
// Run-gated divider giving one-cycle count ticks at several rates.
// Assumes the sub-clock rate is stood in for by the slowest divider tap.
`timescale 1ns/1ns
module dmct_prescaler
  import dmct_pkg::*;
(
  input  wire logic            core_clk,
  input  wire logic            srst,
  input  wire logic            run,
  output dmct_pkg::dmct_tick_t tick_q
);
  import dmct_pkg::*;

  logic [PRE_W-1:0] cnt_q;
  dmct_tick_t       tick_d;

  assign tick_d.div4  = run & ((cnt_q & MASK_DIV4) == MASK_DIV4);
  assign tick_d.div16 = run & ((cnt_q & MASK_D16) == MASK_D16);
  assign tick_d.div32 = run & ((cnt_q & MASK_D32) == MASK_D32);
  assign tick_d.sub4  = run & ((cnt_q & MASK_SUB) == MASK_SUB);

  // Halted in module standby so no tick is pending on wake-up
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      cnt_q  <= PRE_RST;
      tick_q <= '0;
    end
    else
    begin
      cnt_q  <= run ? cnt_q + 7'h01 : cnt_q;
      tick_q <= tick_d;
    end
  end
endmodule

// *** dmct_timer.sv ***
// Dual mode compare timer: counters, compare, status flags, byte port.
// Assumes a CPU-side 8-bit port on the core clock, one access per cycle.
//
// What this block does
// RULE_01 - Upper 8-bit counter rolling FF to 00 sets high overflow flag.
// RULE_02 - High overflow flag clears on writing 0 after reading it as 1.
// RULE_03 - Upper counter equal to upper compare sets high match flag.
// RULE_04 - High match flag clears on writing 0 after reading it as 1.
// RULE_05 - Status bit 5 enables the high overflow interrupt request.
// RULE_06 - Status bit 4 clears counter on match, full or upper by mode.
// RULE_07 - Lower counter rolling FF to 00 sets low overflow flag.
// RULE_08 - Lower counter equal to lower compare sets low match flag.
// RULE_09 - Status bit 1 enables the low overflow interrupt request.
// RULE_10 - Status bit 0 clears the lower counter on a lower match.
// RULE_11 - Flag bits accept only a written 0; other four bits read-write.
// RULE_12 - Status and control register resets to zero.
// RULE_13 - Module stop bit 2 at 0 halts the timer; resets to 1.
// RULE_14 - An 8-bit temporary latch carries 16-bit byte accesses.
// RULE_15 - In 16-bit mode software accesses upper byte first, in pairs.
// RULE_16 - In 8-bit mode byte accesses may come in any order.
// RULE_17 - Upper write goes to latch; lower write loads both bytes.
// RULE_18 - Upper counter read latches lower byte for the next read.
// RULE_19 - Compare register reads return both bytes directly.
// RULE_20 - Counter increments per selected tick; a match counts only on such a tick.
// RULE_21 - Mode bit 0 gives one 16-bit counter, 1 two 8-bit counters.
// RULE_22 - In 16-bit mode full wrap FFFF to 0000 sets high overflow.
// RULE_23 - In 16-bit mode full 16-bit equality sets high match flag.
// RULE_24 - Enabled overflow raises the timer interrupt request.
// RULE_25 - Writing 1 to a flag leaves it unchanged.
// RULE_26 - In 8-bit mode byte accesses bypass the latch.
`timescale 1ns/1ns
module dmct_timer
  import dmct_pkg::*;
(
  input  wire logic           core_clk,
  input  wire logic           srst,
  input  dmct_pkg::dmct_req_t cpu_req,
  output logic [7:0]          cpu_rdata_q,
  output logic                high_timer_irq_request_q,
  output logic                low_timer_irq_request_q
);
  import dmct_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] clkctl_q;
  logic [3:0] ctl_bits_q;
  logic       mstop_q;
  logic [7:0] cnt_hi_q;
  logic [7:0] cnt_lo_q;
  logic [7:0] cmp_hi_q;
  logic [7:0] cmp_lo_q;
  logic [7:0] temp_q;
  logic       hi_ovf_q;
  logic       hi_match_q;
  logic       lo_ovf_q;
  logic       lo_match_q;
  dmct_tick_t tick;

  // ----------------------------------------------------------------
  // Port decode
  // ----------------------------------------------------------------
  logic       wr_status;
  logic       wr_clkctl;
  logic       wr_mstop;
  logic       wr_cnt_hi;
  logic       wr_cnt_lo;
  logic       wr_cmp_hi;
  logic       wr_cmp_lo;
  logic       rd_status;
  logic       rd_cnt_hi;
  logic       rd_cnt_lo;
  logic [7:0] wdata;

  assign wdata     = cpu_req.wdata;
  assign wr_status = cpu_req.wr & (cpu_req.addr == REG_STATUS);
  assign wr_clkctl = cpu_req.wr & (cpu_req.addr == REG_CLKCTL);
  assign wr_mstop  = cpu_req.wr & (cpu_req.addr == REG_MSTOP);
  assign wr_cnt_hi = cpu_req.wr & (cpu_req.addr == REG_CNT_HI);
  assign wr_cnt_lo = cpu_req.wr & (cpu_req.addr == REG_CNT_LO);
  assign wr_cmp_hi = cpu_req.wr & (cpu_req.addr == REG_CMP_HI);
  assign wr_cmp_lo = cpu_req.wr & (cpu_req.addr == REG_CMP_LO);
  assign rd_status = cpu_req.rd & (cpu_req.addr == REG_STATUS);
  assign rd_cnt_hi = cpu_req.rd & (cpu_req.addr == REG_CNT_HI);
  assign rd_cnt_lo = cpu_req.rd & (cpu_req.addr == REG_CNT_LO);

  // ----------------------------------------------------------------
  // Mode and control fields
  // ----------------------------------------------------------------
  logic split;
  logic run;
  logic hi_ovie;
  logic hi_cclr;
  logic lo_ovie;
  logic lo_cclr;

  assign split   = clkctl_q[SPLIT_POS];                    // see RULE_21
  assign run     = mstop_q;                                // see RULE_13
  assign hi_ovie = ctl_bits_q[3];
  assign hi_cclr = ctl_bits_q[2];
  assign lo_ovie = ctl_bits_q[1];
  assign lo_cclr = ctl_bits_q[0];

  function automatic logic pick_tick(input logic [2:0] sel, input dmct_tick_t t);
    logic r;
    r = 1'b0;
    if (sel == CKS_DIV32)
      r = t.div32;
    else if (sel == CKS_DIV16)
      r = t.div16;
    else if (sel == CKS_DIV4)
      r = t.div4;
    else if (sel == CKS_SUB4)
      r = t.sub4;
    return r;
  endfunction

  dmct_prescaler u_pre (
    .core_clk (core_clk),
    .srst     (srst),
    .run      (run),
    .tick_q   (tick)
  );

  // ----------------------------------------------------------------
  // Count, compare and overflow events
  // ----------------------------------------------------------------
  // Match fires as the counter leaves the matching value, one tick late
  logic lo_tick;
  logic hi_tick;
  logic lo_eq;
  logic hi_eq;
  logic lo_cmp_ev;
  logic hi_cmp_ev;
  logic lo_clr;
  logic hi_clr;
  logic lo_ovf_ev;
  logic hi_ovf_ev;
  logic load_lo;
  logic load_hi;

  assign lo_tick   = run & pick_tick(clkctl_q[2:0], tick);  // see RULE_20
  assign lo_eq     = (cnt_lo_q == cmp_lo_q);
  assign hi_eq     = (cnt_hi_q == cmp_hi_q);
  // A compare write in the matching cycle voids that match
  assign lo_cmp_ev = lo_tick & lo_eq & ~wr_cmp_lo;         // see RULE_08
  assign hi_cmp_ev = split ? (hi_tick & hi_eq & ~wr_cmp_hi)          // see RULE_03
                           : (lo_tick & lo_eq & hi_eq & ~wr_cmp_lo); // see RULE_23
  assign lo_clr    = split ? (lo_cmp_ev & lo_cclr)         // see RULE_10
                           : (hi_cmp_ev & hi_cclr);        // see RULE_06
  assign hi_clr    = hi_cmp_ev & hi_cclr;                  // see RULE_06
  assign hi_tick   = split ? (run & pick_tick(clkctl_q[6:4], tick))
                           : (lo_tick & (cnt_lo_q == BYTE_MAX) & ~lo_clr);
  assign load_lo   = wr_cnt_lo;
  assign load_hi   = split ? wr_cnt_hi : wr_cnt_lo;
  // A counter write in the overflow cycle suppresses the overflow
  assign lo_ovf_ev = lo_tick & (cnt_lo_q == BYTE_MAX) & ~lo_clr & ~load_lo; // see RULE_07
  assign hi_ovf_ev = hi_tick & (cnt_hi_q == BYTE_MAX) & ~hi_clr & ~load_hi; // see RULE_01
  // In 16-bit mode hi_tick carries from the low byte, so this is the
  // full FFFF to 0000 wrap                                 see RULE_22

  logic [7:0] cnt_lo_d;
  logic [7:0] cnt_hi_d;

  assign cnt_lo_d = load_lo ? wdata
                  : lo_clr  ? CNT_RST
                  : lo_tick ? cnt_lo_q + 8'h01 : cnt_lo_q;
  // Upper byte comes from the latch in 16-bit mode        see RULE_17
  assign cnt_hi_d = load_hi ? (split ? wdata : temp_q)     // see RULE_26
                  : hi_clr  ? CNT_RST
                  : hi_tick ? cnt_hi_q + 8'h01 : cnt_hi_q;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      cnt_lo_q <= CNT_RST;
      cnt_hi_q <= CNT_RST;
    end
    else
    begin
      cnt_lo_q <= cnt_lo_d;
      cnt_hi_q <= cnt_hi_d;
    end
  end

  // ----------------------------------------------------------------
  // Compare registers and temporary latch
  // ----------------------------------------------------------------
  // Lone upper-byte writes in 16-bit mode are lost     see RULE_15
  logic       temp_ld;
  logic [7:0] temp_d;
  logic [7:0] cmp_hi_d;

  assign temp_ld  = ~split & (wr_cnt_hi | wr_cmp_hi | rd_cnt_hi); // see RULE_14
  assign temp_d   = rd_cnt_hi ? cnt_lo_q : wdata;          // see RULE_18
  assign cmp_hi_d = split ? (wr_cmp_hi ? wdata : cmp_hi_q) // see RULE_16
                          : (wr_cmp_lo ? temp_q : cmp_hi_q);

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      cmp_hi_q <= CMP_RST;
      cmp_lo_q <= CMP_RST;
      temp_q   <= CNT_RST;
    end
    else
    begin
      cmp_hi_q <= cmp_hi_d;
      cmp_lo_q <= wr_cmp_lo ? wdata : cmp_lo_q;
      temp_q   <= temp_ld ? temp_d : temp_q;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      clkctl_q   <= CLKCTL_RST;
      ctl_bits_q <= {STATUS_RST[HI_OVIE_POS], STATUS_RST[HI_CCLR_POS],
                     STATUS_RST[LO_OVIE_POS], STATUS_RST[LO_CCLR_POS]}; // see RULE_12
      mstop_q    <= MSTOP_RST[MSTOP_POS];                  // see RULE_13
    end
    else
    begin
      clkctl_q   <= wr_clkctl ? wdata : clkctl_q;
      if (wr_status)                                       // see RULE_11
        ctl_bits_q <= {wdata[HI_OVIE_POS], wdata[HI_CCLR_POS],
                       wdata[LO_OVIE_POS], wdata[LO_CCLR_POS]};
      mstop_q    <= wr_mstop ? wdata[MSTOP_POS] : mstop_q;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  dmct_flag u_hi_ovf (
    .core_clk (core_clk),
    .srst     (srst),
    .set      (hi_ovf_ev),
    .rd       (rd_status),
    .clr      (wr_status & ~wdata[HI_OVF_POS]),            // see RULE_02
    .flag_q   (hi_ovf_q)
  );

  dmct_flag u_hi_match (
    .core_clk (core_clk),
    .srst     (srst),
    .set      (hi_cmp_ev),
    .rd       (rd_status),
    .clr      (wr_status & ~wdata[HI_MATCH_POS]),          // see RULE_04
    .flag_q   (hi_match_q)
  );

  dmct_flag u_lo_ovf (
    .core_clk (core_clk),
    .srst     (srst),
    .set      (lo_ovf_ev),
    .rd       (rd_status),
    .clr      (wr_status & ~wdata[LO_OVF_POS]),            // see RULE_07
    .flag_q   (lo_ovf_q)
  );

  dmct_flag u_lo_match (
    .core_clk (core_clk),
    .srst     (srst),
    .set      (lo_cmp_ev),
    .rd       (rd_status),
    .clr      (wr_status & ~wdata[LO_MATCH_POS]),          // see RULE_08
    .flag_q   (lo_match_q)
  );

  // ----------------------------------------------------------------
  // Read data and interrupt requests
  // ----------------------------------------------------------------
  logic [7:0] status_rd;
  logic [7:0] mstop_rd;
  logic [7:0] rdata_d;
  logic       irq_hi_d;
  logic       irq_lo_d;

  assign status_rd = {hi_ovf_q, hi_match_q, hi_ovie, hi_cclr,
                      lo_ovf_q, lo_match_q, lo_ovie, lo_cclr};
  // Other modules own the remaining stop bits; they read as 1 here
  assign mstop_rd  = mstop_q ? MSTOP_RST : (MSTOP_RST & ~(8'h01 << MSTOP_POS));

  always_comb
  begin
    rdata_d = RD_IDLE;
    if (!cpu_req.rd)
      rdata_d = RD_IDLE;
    else if (cpu_req.addr == REG_STATUS)
      rdata_d = status_rd;
    else if (cpu_req.addr == REG_MSTOP)
      rdata_d = mstop_rd;
    else if (cpu_req.addr == REG_CNT_HI)
      rdata_d = cnt_hi_q;
    else if (cpu_req.addr == REG_CNT_LO)
      rdata_d = split ? cnt_lo_q : temp_q;                 // see RULE_18
    else if (cpu_req.addr == REG_CMP_HI)
      rdata_d = cmp_hi_q;                                  // see RULE_19
    else if (cpu_req.addr == REG_CMP_LO)
      rdata_d = cmp_lo_q;                                  // see RULE_19
  end

  assign irq_hi_d = (hi_ovf_ev & hi_ovie) | hi_cmp_ev;     // see RULE_05
  assign irq_lo_d = (lo_ovf_ev & lo_ovie) | lo_cmp_ev;     // see RULE_09

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      cpu_rdata_q              <= RD_IDLE;
      high_timer_irq_request_q <= 1'b0;
      low_timer_irq_request_q  <= 1'b0;
    end
    else
    begin
      cpu_rdata_q              <= rdata_d;
      high_timer_irq_request_q <= irq_hi_d;                // see RULE_24
      low_timer_irq_request_q  <= irq_lo_d;                // see RULE_24
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  a_hi_ovf_set: assert property (hi_ovf_ev |=> hi_ovf_q) // see RULE_01
    else $error("high overflow event did not set flag");
  a_hi_ovf_cause: assert property ($rose(hi_ovf_q) |-> $past(hi_ovf_ev)) // see RULE_22
    else $error("high overflow flag rose without an overflow");
  a_hi_ovf_clear: assert property (                      // see RULE_02
    (rd_status & hi_ovf_q & ~hi_ovf_ev) ##1 ~hi_ovf_ev
    ##1 (wr_status & ~wdata[HI_OVF_POS] & ~hi_ovf_ev) |=> ~hi_ovf_q)
    else $error("high overflow flag not cleared by read then write 0");
  a_hi_match_set: assert property (hi_cmp_ev |=> hi_match_q) // see RULE_03
    else $error("high match event did not set flag");
  a_hi_match_clear: assert property (                    // see RULE_04
    (rd_status & hi_match_q & ~hi_cmp_ev) ##1 ~hi_cmp_ev
    ##1 (wr_status & ~wdata[HI_MATCH_POS] & ~hi_cmp_ev) |=> ~hi_match_q)
    else $error("high match flag not cleared by read then write 0");
  a_lo_ovf_set: assert property (                        // see RULE_07
    (lo_tick & cnt_lo_q == BYTE_MAX & ~lo_clr & ~wr_cnt_lo) |=> (lo_ovf_q && cnt_lo_q == 8'h00))
    else $error("low byte wrap did not set low overflow");
  a_lo_match_set: assert property (lo_cmp_ev |=> lo_match_q) // see RULE_08
    else $error("low match event did not set flag");
  a_one_no_clear: assert property (                      // see RULE_25
    (wr_status & wdata[HI_OVF_POS] & hi_ovf_q) |=> hi_ovf_q)
    else $error("writing 1 disturbed a pending flag");
  a_irq_gate: assert property (                          // see RULE_05
    (hi_ovf_ev & ~hi_ovie & ~hi_cmp_ev) |=> ~high_timer_irq_request_q)
    else $error("masked high overflow raised a request");
  a_irq_pass: assert property (                          // see RULE_09
    (lo_ovf_ev & lo_ovie) |=> low_timer_irq_request_q)
    else $error("enabled low overflow raised no request");
  a_lo_clr_match: assert property (                      // see RULE_10
    (split & lo_cmp_ev & lo_cclr & ~wr_cnt_lo) |=> cnt_lo_q == 8'h00)
    else $error("low clear on match failed");
  a_wide_clr: assert property (                          // see RULE_06
    (~split & hi_cmp_ev & hi_cclr & ~wr_cnt_lo) |=> {cnt_hi_q, cnt_lo_q} == 16'h0000)
    else $error("full clear on match failed");
  a_wide_count: assert property (                        // see RULE_21
    (~split & lo_tick & ~lo_clr & ~wr_cnt_lo & ~wr_clkctl)
    |=> {cnt_hi_q, cnt_lo_q} == $past({cnt_hi_q, cnt_lo_q}) + 16'h0001)
    else $error("16-bit counter did not step by one");
  a_temp_write: assert property (                        // see RULE_17
    (~split & wr_cnt_hi) ##1 (~cpu_req.wr & ~cpu_req.rd) ##1 (~split & wr_cnt_lo)
    |=> (cnt_hi_q == $past(wdata, 3) && cnt_lo_q == $past(wdata)))
    else $error("paired counter write did not load both bytes");
  a_temp_read: assert property (                         // see RULE_18
    (~split & rd_cnt_hi) ##1 (~cpu_req.rd & ~cpu_req.wr) ##1 (~split & rd_cnt_lo)
    |=> cpu_rdata_q == $past(cnt_lo_q, 3))
    else $error("lower byte read did not return latched value");
  a_cmp_direct: assert property (                        // see RULE_19
    (cpu_req.rd & cpu_req.addr == REG_CMP_LO) |=> cpu_rdata_q == $past(cmp_lo_q))
    else $error("compare read not direct");
  a_standby_hold: assert property (                      // see RULE_13
    (~mstop_q & ~cpu_req.wr) |=> $stable({cnt_hi_q, cnt_lo_q}))
    else $error("counter moved in module standby");
  a_reset_zero: assert property (disable iff (1'b0)      // see RULE_12
    srst |=> (status_rd == STATUS_RST && mstop_q))
    else $error("status not zero after reset");

  c_hi_ovf: cover property (hi_ovf_ev ##1 rd_status);
  c_split_match: cover property (split & lo_cmp_ev & lo_cclr);
  c_pair_write: cover property ((~split & wr_cnt_hi) ##1 (~split & wr_cnt_lo));
  c_flag_clear: cover property ($fell(hi_match_q));
endmodule

// *** dmct_cpu.sv ***
// CPU side of the 8-bit peripheral port: byte read and write cycles.
// Assumes callers start each cycle just after a falling clock edge.
`timescale 1ns/1ns
module dmct_cpu
  import dmct_pkg::*;
(
  input  wire logic           core_clk,
  output dmct_pkg::dmct_req_t cpu_req,
  input  wire logic [7:0]     cpu_rdata_q
);
  import dmct_pkg::*;

  // ----------------------------------------------------------------
  // Byte cycles
  // ----------------------------------------------------------------
  initial cpu_req = '{1'b0, 1'b0, 3'h7, 8'h5A};

  // Idle data bus shows the inverse, never a stale copy
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    cpu_req = '{1'b0, 1'b1, a, d};
    @(negedge core_clk);
    cpu_req.wr = 1'b0;
    cpu_req.wdata = ~d;
    @(negedge core_clk);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    cpu_req = '{1'b1, 1'b0, a, cpu_req.wdata};
    @(negedge core_clk);
    // Registered read data stands only in the cycle after the strobe
    d = cpu_rdata_q;
    cpu_req.rd = 1'b0;
    @(negedge core_clk);
  endtask
endmodule

// *** dual_mode_compare_timer_status_test.sv ***
// Self-checking bench for the dual mode compare timer.
// Assumes the port model in dmct_cpu and a 250 MHz core clock.
`timescale 1ns/1ns
module dual_mode_compare_timer_status_test;
  import dmct_pkg::*;

  logic       core_clk = 1'b0;
  logic       srst     = 1'b1;
  dmct_req_t  cpu_req;
  logic [7:0] cpu_rdata_q;
  logic       hi_irq;
  logic       lo_irq;
  logic [7:0] d;
  int         n_fail = 0;
  int         checks_done = 0;
  int         hi_seen = 0;
  int         lo_seen = 0;

  always #2 core_clk = ~core_clk;

  always @(negedge core_clk)
  begin
    if (hi_irq === 1'b1) hi_seen++;
    if (lo_irq === 1'b1) lo_seen++;
  end

  dmct_cpu i_dmct_cpu (.core_clk(core_clk), .cpu_req(cpu_req), .cpu_rdata_q(cpu_rdata_q));

  dmct_timer i_dmct_timer (
    .core_clk                 (core_clk),
    .srst                     (srst),
    .cpu_req                  (cpu_req),
    .cpu_rdata_q              (cpu_rdata_q),
    .high_timer_irq_request_q (hi_irq),
    .low_timer_irq_request_q  (lo_irq)
  );

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rchk(input string what, input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] v;
    i_dmct_cpu.rd(a, v);
    chk(what, exp, v);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Whole run is well under 1500 cycles
  initial
  begin
    #12000;
    n_fail++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10) @(negedge core_clk);
    srst = 1'b0;
    rchk("status", REG_STATUS, STATUS_RST);
    rchk("cnt_hi", REG_CNT_HI, CNT_RST);
    rchk("cnt_lo", REG_CNT_LO, CNT_RST);
    rchk("cmp_hi", REG_CMP_HI, CMP_RST);
    rchk("mstop", REG_MSTOP, MSTOP_RST);
    rchk("unmapped", 3'h7, RD_IDLE);
    $display("test reset done");
    // Upper byte first in 16-bit mode
    i_dmct_cpu.wr(REG_CNT_HI, 8'hAA);
    i_dmct_cpu.wr(REG_CNT_LO, 8'h55);
    rchk("cnt_hi", REG_CNT_HI, 8'hAA);
    rchk("cnt_lo", REG_CNT_LO, 8'h55);
    i_dmct_cpu.wr(REG_CNT_HI, 8'h77);
    rchk("lone_hi", REG_CNT_HI, 8'hAA);
    rchk("lone_lo", REG_CNT_LO, 8'h55);
    i_dmct_cpu.wr(REG_CMP_HI, 8'h12);
    i_dmct_cpu.wr(REG_CMP_LO, 8'h34);
    rchk("cmp_lo", REG_CMP_LO, 8'h34);
    rchk("cmp_hi", REG_CMP_HI, 8'h12);
    $display("test latch done");
    i_dmct_cpu.wr(REG_STATUS, 8'hFF);
    rchk("status_rw", REG_STATUS, 8'h33);
    i_dmct_cpu.wr(REG_STATUS, 8'h22);
    $display("test status done");
    // Split mode, both halves on the /4 tap, set up while halted
    i_dmct_cpu.wr(REG_MSTOP, 8'h00);
    i_dmct_cpu.wr(REG_CLKCTL, 8'h66);
    i_dmct_cpu.wr(REG_CNT_LO, 8'hFD);
    rchk("split_lo", REG_CNT_LO, 8'hFD);
    i_dmct_cpu.wr(REG_CNT_HI, 8'hFD);
    i_dmct_cpu.wr(REG_CMP_LO, 8'h40);
    i_dmct_cpu.wr(REG_CMP_HI, 8'h40);
    repeat (20) @(negedge core_clk);
    rchk("standby_hi", REG_CNT_HI, 8'hFD);
    hi_seen = 0;
    lo_seen = 0;
    i_dmct_cpu.wr(REG_MSTOP, 8'hFF);
    repeat (24) @(negedge core_clk);
    i_dmct_cpu.wr(REG_MSTOP, 8'h00);
    rchk("ovf_flags", REG_STATUS, 8'hAA);
    chk("hi_irq", 8'h01, 8'(hi_seen));
    chk("lo_irq", 8'h01, 8'(lo_seen));
    i_dmct_cpu.wr(REG_STATUS, 8'hAA);
    rchk("flags_kept", REG_STATUS, 8'hAA);
    i_dmct_cpu.wr(REG_STATUS, 8'h22);
    rchk("flags_clr", REG_STATUS, 8'h22);
    $display("test overflow done");
    i_dmct_cpu.wr(REG_CNT_HI, 8'h00);
    i_dmct_cpu.wr(REG_CNT_LO, 8'h00);
    i_dmct_cpu.wr(REG_CMP_HI, 8'h03);
    i_dmct_cpu.wr(REG_CMP_LO, 8'h05);
    i_dmct_cpu.wr(REG_STATUS, 8'h11);
    i_dmct_cpu.wr(REG_MSTOP, 8'hFF);
    repeat (60) @(negedge core_clk);
    i_dmct_cpu.wr(REG_MSTOP, 8'h00);
    rchk("match_flags", REG_STATUS, 8'h55);
    i_dmct_cpu.wr(REG_STATUS, 8'h00);
    rchk("match_clr", REG_STATUS, 8'h00);
    i_dmct_cpu.rd(REG_CNT_HI, d);
    chk("hi_cleared", 8'h01, {7'h00, d <= 8'h03});
    i_dmct_cpu.rd(REG_CNT_LO, d);
    chk("lo_cleared", 8'h01, {7'h00, d <= 8'h05});
    $display("test match done");
    // Full 16-bit wrap from FFFE
    i_dmct_cpu.wr(REG_CLKCTL, 8'h06);
    i_dmct_cpu.wr(REG_CNT_HI, 8'hFF);
    i_dmct_cpu.wr(REG_CNT_LO, 8'hFE);
    i_dmct_cpu.wr(REG_MSTOP, 8'hFF);
    repeat (16) @(negedge core_clk);
    i_dmct_cpu.wr(REG_MSTOP, 8'h00);
    rchk("wide_ovf", REG_STATUS, 8'h88);
    $display("test wide overflow done");
    // Full clear on a 16-bit match at 0002
    i_dmct_cpu.wr(REG_STATUS, 8'h10);
    rchk("wide_ovf_clr", REG_STATUS, 8'h10);
    i_dmct_cpu.wr(REG_CMP_HI, 8'h00);
    i_dmct_cpu.wr(REG_CMP_LO, 8'h02);
    i_dmct_cpu.wr(REG_CNT_HI, 8'h00);
    i_dmct_cpu.wr(REG_CNT_LO, 8'h00);
    i_dmct_cpu.wr(REG_MSTOP, 8'hFF);
    repeat (16) @(negedge core_clk);
    i_dmct_cpu.wr(REG_MSTOP, 8'h00);
    rchk("wide_match", REG_STATUS, 8'h54);
    rchk("wide_clr_hi", REG_CNT_HI, 8'h00);
    i_dmct_cpu.rd(REG_CNT_LO, d);
    chk("wide_clr_lo", 8'h01, {7'h00, d <= 8'h02});
    $display("test wide clear done");
    complete_run();
  end
endmodule
